// ===== include/mac_regs_pkg.sv
// Purpose: shared constants, types and register map of the mac-side register block
// Assumes: word addresses of 14 bits cover the 64 KiB byte space of the block
// Notes:   byte offsets are kept as printed; word index is the offset shifted by two
package mac_regs_pkg;

    // ****************************************************************
    // address map
    // ****************************************************************
    localparam int          WADDR_W          = 14;
    localparam logic [3:0]  REGION_TX_CTRL   = 4'h0;
    localparam logic [3:0]  REGION_TX_BUF    = 4'h1;
    localparam logic [3:0]  REGION_RX_VIEW   = 4'h2;
    localparam logic [3:0]  REGION_RX_CTRL   = 4'h3;
    localparam logic [3:0]  REGION_MAC       = 4'h4;
    localparam logic [15:0] TX_LEN_OFFSET    = 16'h0000;
    localparam logic [15:0] HDR_VAL_OFFSET   = 16'h2000;
    localparam logic [15:0] HDR_EN_OFFSET    = 16'h2028;
    localparam logic [15:0] RX_END_OFFSET    = 16'h2040;
    localparam logic [15:0] FIFO_CNT_OFFSET  = 16'h2044;
    localparam logic [15:0] EVENT_OFFSET     = 16'h4000;
    localparam logic [15:0] LINK_OFFSET      = 16'h4004;
    localparam logic [15:0] VERSION_OFFSET   = 16'h4008;

    // ****************************************************************
    // field sizes
    // ****************************************************************
    localparam int          HDR_BYTES        = 38;
    localparam int          HDR_WORDS        = 10;
    localparam int          TX_LEN_W         = 12;
    localparam int          END_ADDR_W       = 9;
    localparam int          END_CNT_W        = 5;
    localparam int          END_FIFO_DEPTH   = 16;
    localparam int          TX_FIFO_DEPTH    = 8;
    localparam int          TX_BUF_WORDS     = 1024;
    localparam int          RX_BUF_WORDS     = 128;
    localparam int          BUSY_BIT         = 0;
    localparam int          EVENT_BIT        = 0;
    localparam int          LINK_BIT         = 0;
    localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_e;

    typedef struct packed {
        logic        strobe;
        logic [3:0]  lanes;
        logic [31:0] word;
    } reg_write_s;

    typedef struct packed {
        logic        valid;
        logic        last;
        logic [7:0]  data;
    } rx_beat_s;

    typedef struct packed {
        logic        last;
        logic [7:0]  data;
    } tx_beat_s;

endpackage : mac_regs_pkg

// ===== hw/mac_side_register_block.sv
// Contract
// - byte space 0x0000-0x0FFF is sender control, 0x3000-0x3FFF receiver control
// - window 0x1000-0x1FFF writes the transmit frame buffer only
// - window 0x2000-0x2FFF reads the receive frame buffer only; code decodes it like 0x3000, so filter writes and pointer reads also land here
// - window 0x4000-0x4FFF holds the mac core status
// - upper word address bits select the addressed region
// - read data passes two mux stages and an output register; valid exactly three cycles after request
// - writing the length loads 12-bit byte count and starts sending at once; the write is ignored while busy or when the count is zero
// - reading the length register returns sender busy in bit 0
// - filter compares frame bytes 0..37 with 38 programmed bytes, four per word
// - 38 compare enables, 32 in first word, 6 in second word
// - a byte with enable low counts as matching
// - reading end pointer returns 9-bit address and pops one fifo entry
// - end pointer fifo entry count readable as 5 bits
// - fifo full latches event bit 0; writing 1 clears it; a write while the fifo is still full leaves it set
// - link state readable in bit 0, 1 when up
// - mac core 32-bit version readable
// - only frames passing the filter are stored; others are dropped
//
// Purpose: registers, raw frame sender and filtering frame receiver of the mac domain
// Assumes: all ports are synchronous to clock_in; assertions assume ce_in stays high
// Notes:   receive regions 0x2000 and 0x3000 decode alike; frames under 38 bytes drop
`timescale 1ns/10ps

// ********************************************************************
// generic fifo
// ********************************************************************
module stream_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic                       clock_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       ce_in,
    input  wire logic                       in_valid_in,
    output      logic                       in_ready_out,
    input  wire logic [WIDTH-1:0]           in_data_in,
    output      logic                       out_valid_out,
    input  wire logic                       out_ready_in,
    output      logic [WIDTH-1:0]           out_data_out,
    output      logic [$clog2(DEPTH+1)-1:0] count_out
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad_shape
        $error("stream_fifo needs a power-of-two depth of two or more");
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    wire              push = in_valid_in && in_ready_out;
    wire              pop  = out_valid_out && out_ready_in;

    assign in_ready_out  = (count != CNT_W'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out  = store[rd_ptr];
    assign count_out     = count;

    always_ff @(posedge clock_in)
    begin
        if (ce_in && push)
        begin
            store[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else if (ce_in)
        begin
            wr_ptr <= wr_ptr + PTR_W'(push);
            rd_ptr <= rd_ptr + PTR_W'(pop);
            count  <= count + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule : stream_fifo

// ********************************************************************
// register block
// ********************************************************************
module mac_side_register_block (
    input  wire logic                                  clock_in,
    input  wire logic                                  rst_n_in,
    input  wire logic                                  ce_in,
    input  wire logic [mac_regs_pkg::WADDR_W-1:0]      reg_word_address_in,
    input  wire mac_regs_pkg::reg_write_s              reg_write_in,
    input  wire logic                                  reg_read_request_in,
    output      logic                                  reg_read_valid_out,
    output      logic [31:0]                           reg_read_word_out,
    input  wire mac_regs_pkg::rx_beat_s                rx_beat_in,
    output      mac_regs_pkg::tx_beat_s                tx_beat_out,
    output      logic                                  tx_valid_out,
    input  wire logic                                  tx_ready_in,
    input  wire logic                                  link_up_in,
    input  wire logic [31:0]                           core_version_output_in
);
    import mac_regs_pkg::*;

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic logic is_rx(input logic [3:0] region);
        return (region == REGION_RX_VIEW) || (region == REGION_RX_CTRL);
    endfunction : is_rx

    function automatic logic rx_hit(input logic [WADDR_W-1:0] a, input logic [15:0] off);
        return is_rx(a[13:10]) && (a[9:0] == off[11:2]);
    endfunction : rx_hit

    wire logic [WADDR_W-1:0] addr       = reg_word_address_in;
    wire logic [3:0]         region     = addr[13:10];
    wire logic               wstb       = reg_write_in.strobe;
    wire logic [3:0]         lanes      = reg_write_in.lanes;
    wire logic [31:0]        wword      = reg_write_in.word;
    wire logic               wr_tx_len  = wstb && (addr == TX_LEN_OFFSET[15:2]);
    wire logic               wr_tx_buf  = wstb && (region == REGION_TX_BUF);
    wire logic               wr_hdr_val = wstb && is_rx(region) && (addr[9:0] < 10'(HDR_WORDS));
    wire logic               wr_hdr_en0 = wstb && rx_hit(addr, HDR_EN_OFFSET);
    wire logic               wr_hdr_en1 = wstb && rx_hit(addr, HDR_EN_OFFSET + 16'h0004);
    wire logic               wr_evt_clr = wstb && (addr == EVENT_OFFSET[15:2])
                                          && lanes[0] && wword[EVENT_BIT];
    wire logic               rd_len     = addr == TX_LEN_OFFSET[15:2];
    wire logic               rd_end     = reg_read_request_in && rx_hit(addr, RX_END_OFFSET);

    // ****************************************************************
    // header filter registers
    // ****************************************************************
    logic [7:0]           hdr_val [HDR_BYTES];
    logic [HDR_BYTES-1:0] hdr_en;
    logic [5:0]           hdr_idx [4];

    for (genvar g = 0; g < 4; g++)
    begin : g_hdr_idx
        assign hdr_idx[g] = {addr[3:0], 2'(g)};
    end

    // four bytes per word, byte 0 lowest
    always_ff @(posedge clock_in)
    begin
        if (ce_in && wr_hdr_val)
        begin
            for (int g = 0; g < 4; g++)
            begin
                if (lanes[g] && hdr_idx[g] < 6'(HDR_BYTES))
                begin
                    hdr_val[hdr_idx[g]] <= wword[8*g +: 8];
                end
            end
        end
    end

    for (genvar b = 0; b < HDR_BYTES; b++)
    begin : g_hdr_en
        localparam int LANE = (b % 32) / 8;
        wire logic hit = (b < 32) ? wr_hdr_en0 : wr_hdr_en1;
        always_ff @(posedge clock_in)
        begin
            if (!rst_n_in)
                hdr_en[b] <= 1'b0;
            else if (ce_in && hit && lanes[LANE])
                hdr_en[b] <= wword[b % 32];
        end
    end

    // ****************************************************************
    // raw frame sender
    // ****************************************************************
    logic [31:0]         transmit_frame_buffer [TX_BUF_WORDS];
    tx_state_e           tx_state;
    logic [TX_LEN_W-1:0] tx_len;
    logic [TX_LEN_W-1:0] tx_ptr;
    logic                txf_in_ready;
    logic                txf_out_valid;
    tx_beat_s            txf_out_data;
    tx_beat_s            tx_next_beat;

    wire logic [TX_LEN_W-1:0] next_tx_len = {lanes[1] ? wword[11:8] : tx_len[11:8],
                                             lanes[0] ? wword[7:0]  : tx_len[7:0]};
    wire logic                tx_busy     = (tx_state == TX_SEND) || txf_out_valid;
    wire logic                tx_start    = wr_tx_len && !tx_busy && (next_tx_len != '0);
    wire logic                tx_push     = (tx_state == TX_SEND) && txf_in_ready;
    wire logic [31:0]         tx_word     = transmit_frame_buffer[tx_ptr[11:2]];

    assign tx_next_beat.data = tx_word[8*tx_ptr[1:0] +: 8];
    assign tx_next_beat.last = (tx_ptr == tx_len - TX_LEN_W'(1));

    always_ff @(posedge clock_in)
    begin
        if (ce_in && wr_tx_buf)
        begin
            for (int g = 0; g < 4; g++)
            begin
                if (lanes[g])
                    transmit_frame_buffer[addr[9:0]][8*g +: 8] <= wword[8*g +: 8];
            end
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            tx_state <= TX_IDLE;
            tx_len   <= '0;
            tx_ptr   <= '0;
        end
        else if (ce_in)
        begin
            case (tx_state)
                TX_IDLE:
                begin
                    if (tx_start)
                    begin
                        tx_len   <= next_tx_len;
                        tx_ptr   <= '0;
                        tx_state <= TX_SEND;
                    end
                end
                TX_SEND:
                begin
                    if (tx_push)
                    begin
                        tx_ptr <= tx_ptr + TX_LEN_W'(1);
                        if (tx_next_beat.last)
                            tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    stream_fifo #(
        .WIDTH ($bits(tx_beat_s)),
        .DEPTH (TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .ce_in         (ce_in),
        .in_valid_in   (tx_push),
        .in_ready_out  (txf_in_ready),
        .in_data_in    (tx_next_beat),
        .out_valid_out (txf_out_valid),
        .out_ready_in  (tx_ready_in),
        .out_data_out  (txf_out_data),
        .count_out     ()
    );

    assign tx_valid_out = txf_out_valid;
    assign tx_beat_out  = txf_out_data;

    // ****************************************************************
    // filtering frame receiver
    // ****************************************************************
    logic [31:0]           receive_frame_buffer [RX_BUF_WORDS];
    logic [END_ADDR_W-1:0] rx_wp;
    logic [END_ADDR_W-1:0] rx_commit;
    logic [5:0]            rx_idx;
    logic                  rx_miss;
    logic                  end_in_ready;
    logic                  end_valid;
    logic [END_ADDR_W-1:0] end_head;
    logic [END_CNT_W-1:0]  end_count;
    logic                  fifo_full_event;

    wire logic in_hdr   = rx_idx < 6'(HDR_BYTES);
    wire logic cur_miss = in_hdr && hdr_en[rx_idx] && (rx_beat_in.data != hdr_val[rx_idx]);
    wire logic too_short = rx_idx < 6'(HDR_BYTES - 1);
    wire logic rx_end   = rx_beat_in.valid && rx_beat_in.last;
    wire logic end_push = rx_end && !rx_miss && !cur_miss && !too_short && end_in_ready;
    wire logic end_pop  = rd_end && end_valid;

    always_ff @(posedge clock_in)
    begin
        if (ce_in && rx_beat_in.valid)
            receive_frame_buffer[rx_wp[8:2]][8*rx_wp[1:0] +: 8] <= rx_beat_in.data;
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            rx_wp     <= '0;
            rx_commit <= '0;
            rx_idx    <= '0;
            rx_miss   <= 1'b0;
        end
        else if (ce_in && rx_beat_in.valid)
        begin
            if (rx_beat_in.last)
            begin
                rx_idx  <= '0;
                rx_miss <= 1'b0;
                rx_wp     <= end_push ? rx_wp + END_ADDR_W'(1) : rx_commit;
                rx_commit <= end_push ? rx_wp + END_ADDR_W'(1) : rx_commit;
            end
            else
            begin
                rx_wp   <= rx_wp + END_ADDR_W'(1);
                rx_idx  <= in_hdr ? rx_idx + 6'd1 : rx_idx;
                rx_miss <= rx_miss || cur_miss;
            end
        end
    end

    stream_fifo #(
        .WIDTH (END_ADDR_W),
        .DEPTH (END_FIFO_DEPTH)
    ) u_end_pointer_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .ce_in         (ce_in),
        .in_valid_in   (end_push),
        .in_ready_out  (end_in_ready),
        .in_data_in    (rx_wp),
        .out_valid_out (end_valid),
        .out_ready_in  (rd_end),
        .out_data_out  (end_head),
        .count_out     (end_count)
    );

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            fifo_full_event <= 1'b0;
        else if (ce_in)
            fifo_full_event <= !end_in_ready || (fifo_full_event && !wr_evt_clr);
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [2:0]  rd_valid_pipe;
    logic [3:0]  s1_region;
    logic [31:0] s1_tx;
    logic [31:0] s1_rx;
    logic [31:0] s1_mac;
    logic [31:0] s2_word;

    // busy in bit 0, others zero
    wire logic [31:0] tx_rd  = rd_len ? 32'(tx_busy) << BUSY_BIT : ZERO_WORD;
    wire logic [31:0] rx_rd  = rx_hit(addr, RX_END_OFFSET)   ? 32'(end_head)  :
                               rx_hit(addr, FIFO_CNT_OFFSET) ? 32'(end_count) :
                               (addr[9:0] < 10'(RX_BUF_WORDS)) ?
                                   receive_frame_buffer[addr[6:0]] : ZERO_WORD;
    wire logic [31:0] mac_rd = (addr == EVENT_OFFSET[15:2])   ?
                                   32'(fifo_full_event) << EVENT_BIT :
                               (addr == LINK_OFFSET[15:2])    ? 32'(link_up_in) << LINK_BIT :
                               (addr == VERSION_OFFSET[15:2]) ? core_version_output_in :
                               ZERO_WORD;
    wire logic [31:0] s2_pick = (s1_region == REGION_TX_CTRL) ? s1_tx  :
                                is_rx(s1_region)              ? s1_rx  :
                                (s1_region == REGION_MAC)     ? s1_mac : ZERO_WORD;

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            rd_valid_pipe     <= '0;
            s1_region         <= '0;
            s1_tx             <= '0;
            s1_rx             <= '0;
            s1_mac            <= '0;
            s2_word           <= '0;
            reg_read_word_out <= '0;
        end
        else if (ce_in)
        begin
            rd_valid_pipe <= {rd_valid_pipe[1:0], reg_read_request_in};
            if (reg_read_request_in)
            begin
                s1_region <= region;
                s1_tx     <= tx_rd;
                s1_rx     <= rx_rd;
                s1_mac    <= mac_rd;
            end
            if (rd_valid_pipe[0])
                s2_word <= s2_pick;
            if (rd_valid_pipe[1])
                reg_read_word_out <= s2_word;
        end
    end

    assign reg_read_valid_out = rd_valid_pipe[2];

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_read_req;
        reg_read_request_in;
    endsequence

    sequence s_valid_in_three;
        !reg_read_valid_out ##1 !reg_read_valid_out ##1 reg_read_valid_out;
    endsequence

    property p_read_latency;
        @(posedge clock_in) disable iff (!rst_n_in || !ce_in)
        s_read_req ##0 !rd_valid_pipe[1] ##0 !rd_valid_pipe[0] |=> s_valid_in_three;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read valid not at 3");

    property p_valid_has_cause;
        @(posedge clock_in) disable iff (!rst_n_in || !ce_in)
        reg_read_valid_out |-> $past(reg_read_request_in, 3);
    endproperty
    a_valid_has_cause: assert property (p_valid_has_cause) else $error("stray valid");

    property p_tx_start;
        @(posedge clock_in) disable iff (!rst_n_in || !ce_in)
        tx_start |=> tx_busy && tx_len == $past(next_tx_len);
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("send did not start");

    property p_busy_read;
        @(posedge clock_in) disable iff (!rst_n_in || !ce_in)
        reg_read_request_in && rd_len |-> ##3 reg_read_word_out == 32'($past(tx_busy, 3));
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy bit wrong");

    property p_pop_on_read;
        @(posedge clock_in) disable iff (!rst_n_in || !ce_in)
        end_pop |=> end_count == $past(end_count) - 5'd1 + 5'($past(end_push));
    endproperty
    a_pop_on_read: assert property (p_pop_on_read) else $error("end fifo not popped");

    property p_full_latch;
        @(posedge clock_in) disable iff (!rst_n_in || !ce_in)
        end_count == 5'(END_FIFO_DEPTH) |=> fifo_full_event;
    endproperty
    a_full_latch: assert property (p_full_latch) else $error("full not latched");

    property p_event_clear;
        @(posedge clock_in) disable iff (!rst_n_in || !ce_in)
        wr_evt_clr && end_in_ready |=> !fifo_full_event;
    endproperty
    a_event_clear: assert property (p_event_clear) else $error("event not cleared");

    property p_filter_drop;
        @(posedge clock_in) disable iff (!rst_n_in || !ce_in)
        rx_end && (rx_miss || cur_miss) |-> !end_push ##1 rx_wp == $past(rx_commit);
    endproperty
    a_filter_drop: assert property (p_filter_drop) else $error("bad frame kept");

    property p_wo_reads_zero;
        @(posedge clock_in) disable iff (!rst_n_in || !ce_in)
        reg_read_request_in && region == REGION_TX_BUF |-> ##3 reg_read_word_out == ZERO_WORD;
    endproperty
    a_wo_reads_zero: assert property (p_wo_reads_zero) else $error("buffer read not zero");

endmodule : mac_side_register_block

// ===== testbench/bridge_model.sv
// Purpose: register-side model of the clock-crossing bridge
// Assumes: requests launched at rising edges by non-blocking assignment
// Notes:   one request at a time; read waits at most eight edges
`timescale 1ns/10ps
module bridge_model (
    input  wire logic                      clock_in,
    input  wire logic                      valid_in,
    input  wire logic [31:0]               word_in,
    output      logic [13:0]               addr_out,
    output      mac_regs_pkg::reg_write_s  wr_out,
    output      logic                      req_out
);
    import mac_regs_pkg::*;
    initial
    begin
        addr_out = '0;
        wr_out   = '0;
        req_out  = 1'b0;
    end
    task automatic wr(input logic [15:0] off, input logic [31:0] d);
        @(posedge clock_in);
        addr_out <= off[15:2];
        wr_out   <= '{1'b1, 4'hf, d};
        @(posedge clock_in);
        wr_out.strobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] off, output logic [31:0] d, output int lat);
        @(posedge clock_in);
        addr_out <= off[15:2];
        req_out  <= 1'b1;
        @(posedge clock_in);
        req_out <= 1'b0;
        d = '0;
        for (lat = 1; lat < 9; lat++)
        begin
            @(posedge clock_in);
            if (valid_in === 1'b1)
            begin
                d = word_in;
                break;
            end
        end
    endtask : rd
endmodule : bridge_model

// ===== testbench/tb.sv
// Purpose: self-checking bench of the mac-side register block
// Assumes: clock enable held high
// Notes:   bridge model issues all register traffic
`timescale 1ns/10ps
module tb;
    import mac_regs_pkg::*;
    logic clock_in = 0, rst_n_in = 0, valid, tx_valid, req, link = 0, tx_ready = 0;
    logic [13:0] addr;
    logic [31:0] rword, ver = 32'h1234_5678;
    reg_write_s  wr;
    rx_beat_s    rx = '0;
    tx_beat_s    txb;
    int          n_fail = 0, checks = 0;
    initial forever #25 clock_in = ~clock_in;
    bridge_model u_bridge_model (.clock_in(clock_in), .valid_in(valid), .word_in(rword),
        .addr_out(addr), .wr_out(wr), .req_out(req));
    mac_side_register_block u_mac_side_register_block (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .ce_in(1'b1), .reg_word_address_in(addr), .reg_write_in(wr),
        .reg_read_request_in(req), .reg_read_valid_out(valid), .reg_read_word_out(rword),
        .rx_beat_in(rx), .tx_beat_out(txb), .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready), .link_up_in(link), .core_version_output_in(ver));
    task automatic stop_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic rd(input logic [15:0] off, input logic [31:0] e);
        logic [31:0] d;
        int lat;
        u_bridge_model.rd(off, d, lat);
        chk(lat, 3);
        chk(d, e);
    endtask : rd
    task automatic frame(input logic [7:0] b0);
        for (int i = 0; i < 38; i++)
        begin
            @(posedge clock_in);
            rx <= '{1'b1, i == 37, (i == 0) ? b0 : 8'(i)};
        end
        @(posedge clock_in);
        rx <= '0;
    endtask : frame
    task automatic t_reset;
        rd(16'h0000, 0);
        rd(16'h2044, 0);
        rd(16'h4000, 0);
        rd(16'h1000, 0);
        rd(16'h5000, 0);
    endtask : t_reset
    task automatic t_status;
        link <= 1'b1;
        rd(16'h4004, 1);
        u_bridge_model.wr(16'h4008, 0);
        rd(16'h4008, ver);
        link <= 1'b0;
        rd(16'h4004, 0);
    endtask : t_status
    task automatic t_tx;
        int k = 0;
        u_bridge_model.wr(16'h1000, 32'h0403_0201);
        u_bridge_model.wr(16'h0000, 3);
        rd(16'h0000, 1);
        tx_ready <= 1'b1;
        for (int n = 0; n < 20 && k < 3; n++)
        begin
            @(posedge clock_in);
            if (tx_valid === 1'b1) chk(txb, {k == 2, 8'(k + 1)});
            if (tx_valid === 1'b1) k++;
        end
        chk(k, 3);
        rd(16'h0000, 0);
    endtask : t_tx
    task automatic t_rx;
        u_bridge_model.wr(16'h2000, 32'h0000_00aa);
        u_bridge_model.wr(16'h2024, 32'h0000_2500);
        u_bridge_model.wr(16'h2028, 1);
        u_bridge_model.wr(16'h202c, 32'h0000_0020);
        frame(8'haa);
        frame(8'h55);
        rd(16'h2044, 1);
        rd(16'h2040, 37);
        rd(16'h2044, 0);
    endtask : t_rx
    task automatic t_full;
        for (int j = 0; j < 16; j++) frame(8'haa);
        rd(16'h2044, 16);
        rd(16'h4000, 1);
        rd(16'h2040, 75);
        u_bridge_model.wr(16'h4000, 1);
        rd(16'h4000, 0);
    endtask : t_full
    initial
    begin
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_status();
        t_tx();
        t_rx();
        t_full();
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clock_in);
        n_fail++;
        stop_test();
    end
endmodule : tb
